// >>> design/crts_pkg.sv
package crts_pkg;
   localparam int unsigned IDX_W        = 11;
   localparam int unsigned HREG_CELLS   = 1036;
   localparam int unsigned HREG_HALF    = 522;
   localparam int unsigned COLUMNS      = 1028;
   localparam int unsigned EMPTY_CELLS  = 8;
   localparam int unsigned DARK_CELLS   = 12;
   localparam int unsigned IMAGE_SINGLE = 1004;
   localparam int unsigned IMAGE_DUAL   = 502;
   localparam int unsigned ROW_W        = 11;

   typedef enum logic [1:0] {CLS_EMPTY, CLS_DARK, CLS_IMAGE, CLS_OVER} crts_cls_t;
   typedef enum logic [1:0] {MODE_OUT1, MODE_OUT2, MODE_DUAL, MODE_HALT} crts_mode_t;
   typedef enum logic [1:0] {EXP_IDLE, EXP_RUN, EXP_XFER} crts_exp_t;

   typedef struct packed {
      logic             valid;
      crts_cls_t        cls;
      logic [IDX_W-1:0] idx;
   } crts_tap_t;

   typedef struct packed {
      logic h1;
      logic h2;
      logic l1;
      logic l2;
      logic r1;
      logic r2;
   } crts_hphase_t;

   typedef struct packed {
      logic shutter;
      logic v2b;
      logic v2a;
      logic v1;
      logic discard;
   } crts_vphase_t;
endpackage

// >>> design/crts_sequencer.sv
`timescale 1ns/10ps
module crts_sequencer
(
   input  wire logic                          clk,
   input  wire logic                          srst,
   input  wire logic                          shutter_trigger,
   input  wire logic                          transfer_phase2b,
   input  wire logic                          vertical_phase2a,
   input  wire logic                          vertical_phase1,
   input  wire logic                          line_discard,
   input  wire logic                          horiz_phase1_drive,
   input  wire logic                          horiz_phase2_drive,
   input  wire logic                          left_half_phase1,
   input  wire logic                          left_half_phase2,
   input  wire logic                          right_half_phase1,
   input  wire logic                          right_half_phase2,
   output      logic                          exposing,
   output      logic                          exposure_end,
   output      logic                          row_loaded,
   output      logic                          row_discarded,
   output      logic [crts_pkg::ROW_W-1:0]    row_count,
   output      crts_pkg::crts_mode_t          mode,
   output      crts_pkg::crts_tap_t           tap1,
   output      crts_pkg::crts_tap_t           tap2
);
   crts_pkg::crts_vphase_t          vin;
   crts_pkg::crts_vphase_t          vin_q;
   crts_pkg::crts_hphase_t          hin;
   crts_pkg::crts_exp_t             exp_state;
   crts_pkg::crts_exp_t             next_exp_state;
   logic                            combo_had_xfer;
   logic [crts_pkg::IDX_W-1:0]      hpos;
   logic [crts_pkg::IDX_W-1:0]      next_hpos;
   crts_pkg::crts_mode_t            next_mode;
   crts_pkg::crts_tap_t             next_tap1;
   crts_pkg::crts_tap_t             next_tap2;
   logic                            h1_q;

   // Horizontal position class; trailing dark band only in single mode
   function automatic crts_pkg::crts_cls_t cls_of(input logic [crts_pkg::IDX_W-1:0] i,
                                                  input logic dual);
      logic [crts_pkg::IDX_W-1:0] img_end;
      logic [crts_pkg::IDX_W-1:0] line_end;
      img_end  = dual ? crts_pkg::IDX_W'(crts_pkg::EMPTY_CELLS + crts_pkg::DARK_CELLS
                                          + crts_pkg::IMAGE_DUAL)
                      : crts_pkg::IDX_W'(crts_pkg::EMPTY_CELLS + crts_pkg::DARK_CELLS
                                          + crts_pkg::IMAGE_SINGLE);
      line_end = dual ? img_end : img_end + crts_pkg::IDX_W'(crts_pkg::DARK_CELLS);
      if (i < crts_pkg::IDX_W'(crts_pkg::EMPTY_CELLS))
         cls_of = crts_pkg::CLS_EMPTY;
      else if (i < crts_pkg::IDX_W'(crts_pkg::EMPTY_CELLS + crts_pkg::DARK_CELLS))
         cls_of = crts_pkg::CLS_DARK;
      else if (i < img_end)
         cls_of = crts_pkg::CLS_IMAGE;
      else if (i < line_end)
         cls_of = crts_pkg::CLS_DARK;
      else
         cls_of = crts_pkg::CLS_OVER;
   endfunction

   assign vin = '{shutter: shutter_trigger, v2b: transfer_phase2b, v2a: vertical_phase2a,
                  v1: vertical_phase1, discard: line_discard};
   assign hin = '{h1: horiz_phase1_drive, h2: horiz_phase2_drive, l1: left_half_phase1,
                  l2: left_half_phase2, r1: right_half_phase1, r2: right_half_phase2};

   wire shut_fall  = vin_q.shutter & ~vin.shutter;
   wire xfer_fall  = vin_q.v2b & ~vin.v2b;
   wire combo_now  = vin.v2a & vin.v1;
   wire combo_prev = vin_q.v2a & vin_q.v1;
   wire combo_fall = combo_prev & ~combo_now;
   // A combined pulse that carried the transfer phase is the frame transfer, not a row shift
   wire row_shift  = combo_fall & ~combo_had_xfer & ~vin.v2b;
   wire h_edge     = hin.h1 & ~h1_q;

   // Half direction from the four half phases
   wire halves_same = (hin.l1 == hin.r2) && (hin.l2 == hin.r1) && (hin.l1 != hin.l2);
   wire halves_opp  = (hin.l1 == hin.r1) && (hin.l2 == hin.r2) && (hin.l1 != hin.l2);
   assign next_mode = halves_opp ? crts_pkg::MODE_DUAL :
                      !halves_same ? crts_pkg::MODE_HALT :
                      (hin.l1 == hin.h1) ? crts_pkg::MODE_OUT1 : crts_pkg::MODE_OUT2;

   wire is_dual = (next_mode == crts_pkg::MODE_DUAL);
   wire at_end  = hpos == crts_pkg::IDX_W'(crts_pkg::HREG_CELLS);
   assign next_hpos = row_shift ? '0 : (h_edge && !at_end) ? hpos + 1'b1 : hpos;

   crts_pkg::crts_cls_t cur_cls;
   assign cur_cls = cls_of(hpos, is_dual);

   assign next_tap1.valid = h_edge && (next_mode != crts_pkg::MODE_OUT2)
                            && (next_mode != crts_pkg::MODE_HALT);
   assign next_tap1.cls   = cur_cls;
   assign next_tap1.idx   = hpos;
   assign next_tap2.valid = h_edge && (next_mode != crts_pkg::MODE_OUT1)
                            && (next_mode != crts_pkg::MODE_HALT);
   assign next_tap2.cls   = cur_cls;
   assign next_tap2.idx   = hpos;

   always_comb
   begin
      next_exp_state = exp_state;
      case (exp_state)
         crts_pkg::EXP_IDLE,
         crts_pkg::EXP_RUN:
         begin
            if (vin.v2b)
               next_exp_state = crts_pkg::EXP_XFER;
            else if (shut_fall)
               next_exp_state = crts_pkg::EXP_RUN;
         end
         crts_pkg::EXP_XFER:
         begin
            if (xfer_fall)
               next_exp_state = shut_fall ? crts_pkg::EXP_RUN : crts_pkg::EXP_IDLE;
         end
         default:
            next_exp_state = crts_pkg::EXP_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         vin_q <= '0;
         h1_q  <= 1'b0;
      end
      else
      begin
         vin_q <= vin;
         h1_q  <= hin.h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         exp_state    <= crts_pkg::EXP_IDLE;
         exposing     <= 1'b0;
         exposure_end <= 1'b0;
      end
      else
      begin
         exp_state    <= next_exp_state;
         // Shutter overlapping transfer restarts exposure on its fall
         exposing     <= (next_exp_state == crts_pkg::EXP_RUN) ||
                         (exp_state != crts_pkg::EXP_IDLE && next_exp_state
                          == crts_pkg::EXP_XFER && exposing) ||
                         (shut_fall && vin.v2b);
         exposure_end <= xfer_fall;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         combo_had_xfer <= 1'b0;
         row_loaded     <= 1'b0;
         row_discarded  <= 1'b0;
         row_count      <= '0;
         hpos           <= '0;
         mode           <= crts_pkg::MODE_HALT;
         tap1           <= '0;
         tap2           <= '0;
      end
      else
      begin
         combo_had_xfer <= combo_now ? (combo_had_xfer | vin.v2b) : 1'b0;
         row_loaded     <= row_shift & ~vin.discard;
         row_discarded  <= row_shift & vin.discard;
         row_count      <= row_shift ? row_count + 1'b1 : row_count;
         hpos           <= next_hpos;
         mode           <= next_mode;
         tap1           <= next_tap1;
         tap2           <= next_tap2;
      end
   end

   sequence s_row_shift;
      combo_fall && !combo_had_xfer && !vin.v2b;
   endsequence

   sequence s_dual_edge;
      h_edge && is_dual;
   endsequence

   property p_expo_start;
      @(posedge clk) disable iff (srst) shut_fall && !vin.v2b |=> exposing;
   endproperty
   a_expo_start: assert property (p_expo_start) else $error("exposure not started");

   property p_expo_end;
      @(posedge clk) disable iff (srst)
         xfer_fall && !shut_fall |=> exposure_end && !exposing;
   endproperty
   a_expo_end: assert property (p_expo_end) else $error("exposure not ended");

   property p_overlap;
      @(posedge clk) disable iff (srst) shut_fall && vin.v2b |=> exposing;
   endproperty
   a_overlap: assert property (p_overlap) else $error("overlap shutter lost");

   property p_row;
      @(posedge clk) disable iff (srst)
         s_row_shift |=> (row_loaded ^ row_discarded) && row_count == $past(row_count) + 1'b1;
   endproperty
   a_row: assert property (p_row) else $error("row shift missed");

   property p_hreg_len;
      @(posedge clk) disable iff (srst)
         s_row_shift |=> hpos == '0 ##0 (hpos <= crts_pkg::IDX_W'(crts_pkg::HREG_CELLS))[*8];
   endproperty
   a_hreg_len: assert property (p_hreg_len) else $error("horizontal position bad");

   property p_line_order;
      @(posedge clk) disable iff (srst)
         h_edge && !is_dual && next_mode != crts_pkg::MODE_HALT
         && hpos == crts_pkg::IDX_W'(crts_pkg::EMPTY_CELLS)
         |=> tap1.cls == crts_pkg::CLS_DARK || tap2.cls == crts_pkg::CLS_DARK;
   endproperty
   a_line_order: assert property (p_line_order) else $error("line order wrong");

   property p_single;
      @(posedge clk) disable iff (srst)
         h_edge && halves_same |=> tap1.valid != tap2.valid;
   endproperty
   a_single: assert property (p_single) else $error("single mode drives both");

   property p_dual;
      @(posedge clk) disable iff (srst)
         s_dual_edge ##0 hpos == crts_pkg::IDX_W'(crts_pkg::HREG_HALF)
         |=> tap1.valid && tap2.valid && tap2.cls == crts_pkg::CLS_OVER;
   endproperty
   a_dual: assert property (p_dual) else $error("dual half length wrong");
endmodule

// >>> tb/ccd_readout_timing_sequencer_tb_top.sv
`timescale 1ns/10ps
module ccd_readout_timing_sequencer_tb_top;
   logic                       clk  = 1'b0;
   logic                       srst = 1'b1;
   logic                       dual = 1'b0;
   int                         n_fail = 0;
   int                         check_count = 0;
   int                         seed = 32'hF446;
   int                         k1 = 0;
   int                         k2 = 0;
   int                         n_end = 0;
   int                         n_load = 0;
   int                         n_drop = 0;
   int                         rows = 0;
   int                         n_ref = 0;
   int                         n;
   crts_pkg::crts_mode_t       m;
   crts_pkg::crts_vphase_t     vp;
   crts_pkg::crts_hphase_t     hp;
   logic                       exposing;
   logic                       exposure_end;
   logic                       row_loaded;
   logic                       row_discarded;
   logic [crts_pkg::ROW_W-1:0] row_count;
   crts_pkg::crts_mode_t       mode;
   crts_pkg::crts_tap_t        tap1;
   crts_pkg::crts_tap_t        tap2;

   always #5 clk = ~clk;

   crts_timing_gen u_gen (.clk(clk), .vp(vp), .hp(hp));

   crts_sequencer u_dut (.clk(clk), .srst(srst), .shutter_trigger(vp.shutter),
      .transfer_phase2b(vp.v2b), .vertical_phase2a(vp.v2a), .vertical_phase1(vp.v1),
      .line_discard(vp.discard), .horiz_phase1_drive(hp.h1), .horiz_phase2_drive(hp.h2),
      .left_half_phase1(hp.l1), .left_half_phase2(hp.l2), .right_half_phase1(hp.r1),
      .right_half_phase2(hp.r2), .exposing(exposing), .exposure_end(exposure_end),
      .row_loaded(row_loaded), .row_discarded(row_discarded), .row_count(row_count),
      .mode(mode), .tap1(tap1), .tap2(tap2));

   function automatic crts_pkg::crts_cls_t exp_cls(input int k, input logic d);
      if (k < 8)
         return crts_pkg::CLS_EMPTY;
      if (k < 20)
         return crts_pkg::CLS_DARK;
      if (k < 20 + (d ? crts_pkg::IMAGE_DUAL : crts_pkg::IMAGE_SINGLE))
         return crts_pkg::CLS_IMAGE;
      if (!d && k < crts_pkg::HREG_CELLS)
         return crts_pkg::CLS_DARK;
      return crts_pkg::CLS_OVER;
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Walks the cell position of each output and checks every tap
   always @(posedge clk)
   begin
      if (row_loaded === 1'b1)
      begin
         k1 = 0;
         k2 = 0;
         n_ref = 0;
         n_load++;
      end
      if (exposure_end === 1'b1)
         n_end++;
      if (row_discarded === 1'b1)
         n_drop++;
      if (tap1.valid === 1'b1)
      begin
         chk("tap1 cls", 16'(exp_cls(k1, dual)), 16'(tap1.cls));
         if (k1 < (dual ? 522 : 1036))
            chk("tap1 idx", 16'(k1), 16'(tap1.idx));
         // Central dark columns usable as the zero level reference
         if (tap1.idx > crts_pkg::EMPTY_CELLS
             && tap1.idx < crts_pkg::EMPTY_CELLS + crts_pkg::DARK_CELLS - 1
             && tap1.cls == crts_pkg::CLS_DARK)
            n_ref++;
         k1++;
      end
      if (tap2.valid === 1'b1)
      begin
         chk("tap2 cls", 16'(exp_cls(k2, dual)), 16'(tap2.cls));
         if (k2 < (dual ? 522 : 1036))
            chk("tap2 idx", 16'(k2), 16'(tap2.idx));
         k2++;
      end
   end

   initial
   begin
      repeat (80000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("mode", 16'(crts_pkg::MODE_HALT), 16'(mode));
      u_gen.shutter(400);
      repeat (2) @(posedge clk);
      chk("exposing", 16'h1, 16'(exposing));
      u_gen.frame();
      chk("exposure end", 16'h1, 16'(n_end));
      chk("exposing", 16'h0, 16'(exposing));
      chk("rows", 16'h0, 16'(row_count));
      fork
         u_gen.frame();
         begin
            repeat (550) @(posedge clk);
            u_gen.shutter(100);
            repeat (2) @(posedge clk);
            chk("exposing", 16'h1, 16'(exposing));
         end
      join
      chk("exposure end", 16'h2, 16'(n_end));
      chk("exposing", 16'h0, 16'(exposing));
      $display("capture tests done");
      for (int i = 0; i < 7; i++)
      begin
         m = crts_pkg::crts_mode_t'(i < 3 ? i : ($unsigned($random(seed)) % 3));
         dual = (m == crts_pkg::MODE_DUAL);
         n = (dual ? 523 : 1028) + (i < 3 ? 0 : 16 + ($random(seed) & 7));
         u_gen.row(1'b0);
         rows++;
         u_gen.line(m, n);
         repeat (4) @(posedge clk);
         chk("mode", 16'(m), 16'(mode));
         chk("tap1 count", 16'(m == crts_pkg::MODE_OUT2 ? 0 : n), 16'(k1));
         chk("tap2 count", 16'(m == crts_pkg::MODE_OUT1 ? 0 : n), 16'(k2));
         chk("ref cols", 16'(m == crts_pkg::MODE_OUT2 ? 0 : crts_pkg::DARK_CELLS - 2),
             16'(n_ref));
         $display("line test done mode %0d cycles %0d", m, n);
      end
      u_gen.row(1'b1);
      rows++;
      repeat (2) @(posedge clk);
      chk("rows", 16'(rows), 16'(row_count));
      chk("loaded", 16'(rows - 1), 16'(n_load));
      chk("discarded", 16'h1, 16'(n_drop));
      $display("discard test done");
      report_and_stop();
   end
endmodule

// >>> tb/crts_timing_gen.sv
`timescale 1ns/10ps
module crts_timing_gen
#(
   parameter int VP = 50,
   parameter int V3 = 1000,
   parameter int VR = 20
)
(
   input  wire logic              clk,
   output crts_pkg::crts_vphase_t vp,
   output crts_pkg::crts_hphase_t hp
);
   crts_pkg::crts_mode_t sel = crts_pkg::MODE_OUT1;
   logic                 h1  = 1'b0;
   logic                 h2  = 1'b0;

   initial vp = '0;
   assign hp = '{h1: h1,
                 h2: h2,
                 l1: (sel == crts_pkg::MODE_OUT2) ? h2 : h1,
                 l2: (sel == crts_pkg::MODE_OUT2) ? h1 : h2,
                 r1: (sel == crts_pkg::MODE_OUT1) ? h2 : h1,
                 r2: (sel == crts_pkg::MODE_OUT1) ? h1 : h2};

   task automatic shutter(input int n);
      vp.shutter <= 1'b1;
      repeat (n) @(posedge clk);
      vp.shutter <= 1'b0;
      @(posedge clk);
   endtask

   // Horizontal drives run n cycles and end parked h1 high, h2 low
   task automatic clock_h(input int n);
      repeat (n)
      begin
         h1 <= 1'b0;
         h2 <= 1'b1;
         @(posedge clk);
         h1 <= 1'b1;
         h2 <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic frame;
      fork
         begin
            vp.v2a <= 1'b1;
            repeat (VP) @(posedge clk);
            vp.v2b <= 1'b1;
            vp.v1  <= 1'b1;
            repeat (V3) @(posedge clk);
            vp.v2b <= 1'b0;
            vp.v1  <= 1'b0;
            vp.v2a <= 1'b0;
            repeat (VP) @(posedge clk);
         end
         clock_h((2 * VP + V3) / 2);
      join
   endtask

   task automatic row(input logic d);
      h1 <= 1'b1;
      h2 <= 1'b0;
      vp.discard <= d;
      vp.v2a     <= 1'b1;
      vp.v1      <= 1'b1;
      repeat (4) @(posedge clk);
      vp.v2a <= 1'b0;
      vp.v1  <= 1'b0;
      @(posedge clk);
      vp.discard <= 1'b0;
      repeat (VR) @(posedge clk);
   endtask

   task automatic line(input crts_pkg::crts_mode_t m, input int n);
      sel <= m;
      clock_h(n);
   endtask
endmodule
